// File: hw/pcs_pkg.sv
// Purpose: constants for the primary command and status register logic
// Assumes: one 32-bit configuration dword at offset 0x04 holds both registers
// Notes:   command in bits 15:0, status in bits 31:16
package pcs_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  CMD_STAT_OFFSET  = 8'h04;
   localparam logic [15:0] STATUS_RESET     = 16'h02b0;
   localparam logic [15:0] COMMAND_RESET    = 16'h0000;

   // ---------------------------------------------------------------
   // command bit positions
   // ---------------------------------------------------------------
   localparam int CMD_IO_SPACE       = 0;
   localparam int CMD_MEM_SPACE      = 1;
   localparam int CMD_INITIATOR      = 2;
   localparam int CMD_SPECIAL_CYCLE  = 3;
   localparam int CMD_WRITE_INVAL    = 4;
   localparam int CMD_PALETTE_SNOOP  = 5;
   localparam int CMD_PARITY_RESP    = 6;

   // ---------------------------------------------------------------
   // status bit positions (within the 32-bit dword)
   // ---------------------------------------------------------------
   localparam int ST_CAP_LIST        = 20;
   localparam int ST_SPEED_CAPABLE   = 21;
   localparam int ST_FAST_B2B        = 23;
   localparam int ST_MASTER_PARITY   = 24;
   localparam int ST_SEL_TIMING_LO   = 25;
   localparam int ST_SIG_TGT_ABORT   = 27;
   localparam int ST_RCV_TGT_ABORT   = 28;
   localparam int ST_RCV_MST_ABORT   = 29;
   localparam int ST_SIG_SYS_ERROR   = 30;
   localparam int ST_DET_PARITY      = 31;

   // ---------------------------------------------------------------
   // fixed fields
   // ---------------------------------------------------------------
   localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;
   localparam int         NUM_FLAGS            = 6;

   // ---------------------------------------------------------------
   // palette address decode
   // ---------------------------------------------------------------
   localparam logic [9:0]  PALETTE_ADDR_A   = 10'h3c6;
   localparam logic [9:0]  PALETTE_ADDR_B   = 10'h3c8;
   localparam logic [9:0]  PALETTE_ADDR_C   = 10'h3c9;
   localparam logic [15:0] PALETTE_UPPER    = 16'h0000;

endpackage

// File: hw/pcs_flag_bit.sv
// Purpose: one write-one-to-clear status flag
// Assumes: set and clear are single-cycle strobes on clk
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module pcs_flag_bit (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // controls
   input  wire logic set_evt,
   input  wire logic clr_req,
   // state
   output logic      flag_ff
);

   // ---------------------------------------------------------------
   // flag storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_ff <= 1'b0;
      end else if (set_evt) begin
         flag_ff <= 1'b1;
      end else if (clr_req) begin
         flag_ff <= 1'b0;
      end
   end

endmodule // pcs_flag_bit
`default_nettype wire

// File: hw/pcs_regs.sv
// Purpose: primary command and status registers of a bridge, with the
//          claim and initiate gating that the command bits steer
// Assumes: decode strobes come from logic on clk; the parity pin is asynchronous
// Notes:   configuration access is a one-cycle strobe answered one cycle later
//
// Summary of operation
// R1 - io write to 3c6/3c8/3c9 with upper sixteen bits zero is a palette write
// R2 - palette writes claimed and forwarded only with snoop set, else only in window
// R3 - write invalidate enable reads zero; issue it only when forwarding one
// R4 - special cycles are never claimed; special cycle enable reads zero
// R5 - initiator enable gates secondary claims and primary starts; config unaffected
// R6 - primary memory transactions claimed only while memory space enable is set
// R7 - primary io transactions claimed only while io space enable is set; palette writes with snoop set are claimed even when it is clear
// R8 - writing one clears a status flag; writing zero leaves it
// R9 - address or data parity error on primary bus sets detected parity flag
// R10 - driving the system error output sets the signalled system error flag
// R11 - master abort on own primary transaction sets received master abort
// R12 - target abort on own primary transaction sets received target abort
// R13 - ending a primary transaction with target abort sets signalled target abort
// R14 - select timing field reads fixed value one, medium timing
// R15 - master parity flag needs initiator role, parity error and response enable
// R16 - fast back-to-back capable reads one; such transactions are accepted
// R17 - speed capable bit reads one
// R18 - capability list bit reads one
// R19 - reserved status bits 22 and 19:16 read zero, writes ignored
// R20 - parity response enable gates parity error pin and parity reporting
// R21 - reset clears flags and writable enables; fixed fields keep values
`timescale 1ns/1ps
`default_nettype none
module pcs_regs (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // configuration access
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata_ff,
   output logic             cfg_ack_ff,
   // primary target decode
   input  wire logic        pri_txn_valid,
   input  wire logic        pri_txn_io,
   input  wire logic        pri_txn_mem,
   input  wire logic        pri_txn_special,
   input  wire logic        pri_txn_write,
   input  wire logic        pri_txn_fast_b2b,
   input  wire logic [31:0] pri_txn_addr,
   input  wire logic        pri_in_io_window,
   input  wire logic        pri_in_mem_window,
   output logic             pri_claim_ff,
   output logic             pri_forward_palette_ff,
   // secondary target decode
   input  wire logic        sec_txn_valid,
   input  wire logic        sec_txn_io,
   input  wire logic        sec_txn_mem,
   input  wire logic        sec_txn_cfg,
   output logic             sec_claim_ff,
   // primary initiator
   input  wire logic        init_start_req,
   input  wire logic        init_start_cfg,
   input  wire logic        init_fwd_is_mwi,
   output logic             init_start_ff,
   output logic             init_issue_mwi_ff,
   // bus events
   input  wire logic        addr_parity_err,
   input  wire logic        data_parity_err,
   input  wire logic        init_active,
   input  wire logic        init_master_abort,
   input  wire logic        init_target_abort,
   input  wire logic        tgt_abort_sent,
   input  wire logic        sys_error_req,
   input  wire logic        primary_parity_error_in_n,
   // pins
   output logic             primary_parity_error_n_ff,
   output logic             primary_system_error_n_ff
);

   // ---------------------------------------------------------------
   // command register
   // ---------------------------------------------------------------
   logic       io_space_enable_ff;
   logic       memory_space_enable_ff;
   logic       bus_initiator_enable_ff;
   logic       palette_snoop_enable_ff;
   logic       parity_response_enable_ff;
   logic       cmd_hit;
   logic       cmd_wr_lo;
   logic       stat_wr_hi;
   logic [7:0] nxt_cmd_lo;

   assign cmd_hit    = (cfg_addr == pcs_pkg::CMD_STAT_OFFSET);
   assign cmd_wr_lo  = cfg_wr && cmd_hit && cfg_be[0];
   assign stat_wr_hi = cfg_wr && cmd_hit && cfg_be[3];
   assign nxt_cmd_lo = cfg_wdata[7:0];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         io_space_enable_ff        <= pcs_pkg::COMMAND_RESET[pcs_pkg::CMD_IO_SPACE];     // R21
         memory_space_enable_ff    <= pcs_pkg::COMMAND_RESET[pcs_pkg::CMD_MEM_SPACE];    // R21
         bus_initiator_enable_ff   <= pcs_pkg::COMMAND_RESET[pcs_pkg::CMD_INITIATOR];    // R21
         palette_snoop_enable_ff   <= pcs_pkg::COMMAND_RESET[pcs_pkg::CMD_PALETTE_SNOOP];// R21
         parity_response_enable_ff <= pcs_pkg::COMMAND_RESET[pcs_pkg::CMD_PARITY_RESP];  // R21
      end else if (cmd_wr_lo) begin
         io_space_enable_ff        <= nxt_cmd_lo[pcs_pkg::CMD_IO_SPACE];
         memory_space_enable_ff    <= nxt_cmd_lo[pcs_pkg::CMD_MEM_SPACE];
         bus_initiator_enable_ff   <= nxt_cmd_lo[pcs_pkg::CMD_INITIATOR];
         palette_snoop_enable_ff   <= nxt_cmd_lo[pcs_pkg::CMD_PALETTE_SNOOP];
         parity_response_enable_ff <= nxt_cmd_lo[pcs_pkg::CMD_PARITY_RESP];
      end
   end

   // ---------------------------------------------------------------
   // parity pin synchroniser
   // ---------------------------------------------------------------
   logic perr_meta_ff;
   logic perr_sync_ff;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         perr_meta_ff <= 1'b1;
         perr_sync_ff <= 1'b1;
      end else begin
         perr_meta_ff <= primary_parity_error_in_n;
         perr_sync_ff <= perr_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // error pins
   // ---------------------------------------------------------------
   logic drive_serr;

   assign drive_serr = sys_error_req
                       || (addr_parity_err && parity_response_enable_ff); // R20

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         primary_parity_error_n_ff <= 1'b1;
      end else begin
         primary_parity_error_n_ff <= ~(data_parity_err && parity_response_enable_ff); // R20
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         primary_system_error_n_ff <= 1'b1;
      end else begin
         primary_system_error_n_ff <= ~drive_serr;
      end
   end

   // ---------------------------------------------------------------
   // status flag events
   // ---------------------------------------------------------------
   logic [pcs_pkg::NUM_FLAGS-1:0] flag_set;
   logic [pcs_pkg::NUM_FLAGS-1:0] flag_clr;
   logic [pcs_pkg::NUM_FLAGS-1:0] flag_ff;
   logic                          master_parity_hit;

   assign master_parity_hit = init_active
                              && (data_parity_err || !perr_sync_ff)
                              && parity_response_enable_ff;                   // R15

   // flags in order: bit 24, 27, 28, 29, 30, 31
   assign flag_set[0] = master_parity_hit;                                    // R15
   assign flag_set[1] = tgt_abort_sent;                                       // R13
   assign flag_set[2] = init_active && init_target_abort;                     // R12
   assign flag_set[3] = init_active && init_master_abort;                     // R11
   assign flag_set[4] = !primary_system_error_n_ff;                           // R10
   assign flag_set[5] = addr_parity_err || data_parity_err;                   // R9

   assign flag_clr[0] = stat_wr_hi && cfg_wdata[pcs_pkg::ST_MASTER_PARITY];   // R8
   assign flag_clr[1] = stat_wr_hi && cfg_wdata[pcs_pkg::ST_SIG_TGT_ABORT];   // R8
   assign flag_clr[2] = stat_wr_hi && cfg_wdata[pcs_pkg::ST_RCV_TGT_ABORT];   // R8
   assign flag_clr[3] = stat_wr_hi && cfg_wdata[pcs_pkg::ST_RCV_MST_ABORT];   // R8
   assign flag_clr[4] = stat_wr_hi && cfg_wdata[pcs_pkg::ST_SIG_SYS_ERROR];   // R8
   assign flag_clr[5] = stat_wr_hi && cfg_wdata[pcs_pkg::ST_DET_PARITY];      // R8

   // ---------------------------------------------------------------
   // status flag storage
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < pcs_pkg::NUM_FLAGS; gi++) begin : g_flag
         pcs_flag_bit u_flag (
            .clk     (clk),
            .sys_rst (sys_rst),
            .set_evt (flag_set[gi]),
            .clr_req (flag_clr[gi]),
            .flag_ff (flag_ff[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // read image
   // ---------------------------------------------------------------
   logic [15:0] command_image;
   logic [15:0] status_image;

   always_comb begin
      command_image = pcs_pkg::COMMAND_RESET;
      command_image[pcs_pkg::CMD_IO_SPACE]      = io_space_enable_ff;
      command_image[pcs_pkg::CMD_MEM_SPACE]     = memory_space_enable_ff;
      command_image[pcs_pkg::CMD_INITIATOR]     = bus_initiator_enable_ff;
      command_image[pcs_pkg::CMD_SPECIAL_CYCLE] = 1'b0;                       // R4
      command_image[pcs_pkg::CMD_WRITE_INVAL]   = 1'b0;                       // R3
      command_image[pcs_pkg::CMD_PALETTE_SNOOP] = palette_snoop_enable_ff;
      command_image[pcs_pkg::CMD_PARITY_RESP]   = parity_response_enable_ff;
   end

   always_comb begin
      // fixed fields and zero reserved bits come from the reset image
      status_image = pcs_pkg::STATUS_RESET;                                   // R14 R16 R17 R18 R19
      status_image[pcs_pkg::ST_MASTER_PARITY-16] = flag_ff[0];
      status_image[pcs_pkg::ST_SIG_TGT_ABORT-16] = flag_ff[1];
      status_image[pcs_pkg::ST_RCV_TGT_ABORT-16] = flag_ff[2];
      status_image[pcs_pkg::ST_RCV_MST_ABORT-16] = flag_ff[3];
      status_image[pcs_pkg::ST_SIG_SYS_ERROR-16] = flag_ff[4];
      status_image[pcs_pkg::ST_DET_PARITY-16]    = flag_ff[5];
      status_image[pcs_pkg::ST_SEL_TIMING_LO-16 +: 2] = pcs_pkg::SELECT_TIMING_MEDIUM; // R14
      status_image[pcs_pkg::ST_FAST_B2B-16]      = 1'b1;                      // R16
      status_image[pcs_pkg::ST_SPEED_CAPABLE-16] = 1'b1;                      // R17
      status_image[pcs_pkg::ST_CAP_LIST-16]      = 1'b1;                      // R18
      status_image[22-16]                        = 1'b0;                      // R19
      status_image[3:0]                          = 4'h0;                      // R19
   end

   // ---------------------------------------------------------------
   // configuration answer
   // ---------------------------------------------------------------
   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (cfg_rd && cmd_hit) begin
         if (cfg_be[0]) begin
            nxt_rdata[7:0] = command_image[7:0];
         end
         if (cfg_be[1]) begin
            nxt_rdata[15:8] = command_image[15:8];
         end
         if (cfg_be[2]) begin
            nxt_rdata[23:16] = status_image[7:0];
         end
         if (cfg_be[3]) begin
            nxt_rdata[31:24] = status_image[15:8];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_rdata_ff <= 32'h0000_0000;
      end else begin
         cfg_rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_ack_ff <= 1'b0;
      end else begin
         cfg_ack_ff <= cfg_rd || cfg_wr;
      end
   end

   // ---------------------------------------------------------------
   // primary target claim
   // ---------------------------------------------------------------
   logic palette_write;
   logic nxt_pri_claim;
   logic nxt_palette_fwd;

   always_comb begin
      palette_write = pri_txn_io && pri_txn_write
                      && (pri_txn_addr[31:16] == pcs_pkg::PALETTE_UPPER)
                      && ((pri_txn_addr[9:0] == pcs_pkg::PALETTE_ADDR_A)
                          || (pri_txn_addr[9:0] == pcs_pkg::PALETTE_ADDR_B)
                          || (pri_txn_addr[9:0] == pcs_pkg::PALETTE_ADDR_C)); // R1
   end

   always_comb begin
      nxt_pri_claim   = 1'b0;
      nxt_palette_fwd = 1'b0;
      if (pri_txn_valid && !pri_txn_special) begin                            // R4
         // fast back-to-back is decoded like any other transaction
         if (pri_txn_mem) begin
            nxt_pri_claim = memory_space_enable_ff && pri_in_mem_window;      // R6
         end else if (pri_txn_io) begin
            if (palette_write && palette_snoop_enable_ff) begin
               nxt_pri_claim   = 1'b1;                                        // R2
               nxt_palette_fwd = 1'b1;                                        // R2
            end else begin
               nxt_pri_claim = io_space_enable_ff && pri_in_io_window;        // R2 R7
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pri_claim_ff <= 1'b0;
      end else begin
         pri_claim_ff <= nxt_pri_claim;                                       // R16
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pri_forward_palette_ff <= 1'b0;
      end else begin
         pri_forward_palette_ff <= nxt_palette_fwd;
      end
   end

   // ---------------------------------------------------------------
   // secondary target claim
   // ---------------------------------------------------------------
   logic nxt_sec_claim;

   always_comb begin
      nxt_sec_claim = 1'b0;
      if (sec_txn_valid) begin
         if (sec_txn_cfg) begin
            nxt_sec_claim = 1'b1;                                             // R5
         end else if (sec_txn_io || sec_txn_mem) begin
            nxt_sec_claim = bus_initiator_enable_ff;                          // R5
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sec_claim_ff <= 1'b0;
      end else begin
         sec_claim_ff <= nxt_sec_claim;
      end
   end

   // ---------------------------------------------------------------
   // primary initiator gating
   // ---------------------------------------------------------------
   logic nxt_init_start;

   assign nxt_init_start = init_start_req
                           && (init_start_cfg || bus_initiator_enable_ff);    // R5

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         init_start_ff <= 1'b0;
      end else begin
         init_start_ff <= nxt_init_start;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         init_issue_mwi_ff <= 1'b0;
      end else begin
         init_issue_mwi_ff <= nxt_init_start && init_fwd_is_mwi && !init_start_cfg; // R3
      end
   end

endmodule // pcs_regs
`default_nettype wire

// File: verification/pcs_regs_checker.sv
// Purpose: port checker for the command and status registers
// Assumes: one clock, asynchronous active-high reset
// Notes:   attached by bind from the bench
`timescale 1ns/1ps
`default_nettype none
module pcs_regs_checker (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // configuration
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_rdata_ff,
   input  wire logic        cfg_ack_ff,
   // decode and grants
   input  wire logic        pri_txn_valid,
   input  wire logic        pri_txn_special,
   input  wire logic        pri_claim_ff,
   input  wire logic        sec_txn_valid,
   input  wire logic        sec_txn_cfg,
   input  wire logic        sec_claim_ff,
   input  wire logic        init_start_req,
   input  wire logic        init_start_cfg,
   input  wire logic        init_start_ff,
   // errors
   input  wire logic        data_parity_err,
   input  wire logic        sys_error_req,
   input  wire logic        primary_parity_error_n_ff,
   input  wire logic        primary_system_error_n_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic full_rd;
   assign full_rd = cfg_rd && cfg_addr == 8'h04 && cfg_be == 4'hf;
   a_ack_next_cycle: assert property ((cfg_rd || cfg_wr) |=> cfg_ack_ff)
      else $error("config access not answered");
   a_status_fixed_fields: assert property (cfg_ack_ff && $past(full_rd) |->
      cfg_rdata_ff[26:25] == 2'h1 && cfg_rdata_ff[23:16] == 8'hb0)
      else $error("status fixed field wrong");
   a_cmd_fixed_zero: assert property (cfg_ack_ff && $past(full_rd) |->
      cfg_rdata_ff[15:7] == 9'h000 && cfg_rdata_ff[4:3] == 2'h0)
      else $error("command fixed bits not zero");
   a_special_unclaimed: assert property (pri_txn_valid && pri_txn_special |=> !pri_claim_ff)
      else $error("special cycle claimed");
   a_cfg_start_free: assert property (init_start_req && init_start_cfg |=> init_start_ff)
      else $error("config start refused");
   a_sec_cfg_claim: assert property (sec_txn_valid && sec_txn_cfg |=> sec_claim_ff)
      else $error("secondary config not claimed");
   a_serr_pin_low: assert property (sys_error_req |=> !primary_system_error_n_ff)
      else $error("system error pin not driven");
   a_perr_cause: assert property ($fell(primary_parity_error_n_ff) |-> $past(data_parity_err))
      else $error("parity pin low without cause");
endmodule // pcs_regs_checker
`default_nettype wire

// File: verification/pcs_host_model.sv
// Purpose: target reporting data parity errors on its pin
// Assumes: report is a one-cycle request
// Notes:   the pin is pulled up, so it idles high
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model (
   // clock
   input  wire logic clk,
   // control
   input  wire logic report,
   // pin
   output logic      parity_error_n
);
   logic [1:0] hold_ff = 2'h0;
   always_ff @(posedge clk) begin
      hold_ff <= report ? 2'h3 : hold_ff >> 1;
   end
   assign parity_error_n = ~|hold_ff;
endmodule // pcs_host_model
`default_nettype wire

// File: verification/pcs_regs_bench.sv
// Purpose: self-checking bench for the command and status registers
// Assumes: inputs change on the falling edge
// Notes:   checker bound below
`timescale 1ns/1ps
`default_nettype none
module pcs_regs_bench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cfg_rd, cfg_wr, cfg_ack_ff, pri_txn_valid, pri_txn_fast_b2b, report, init_active;
   logic pri_in_io_window, pri_in_mem_window, sec_txn_valid, sec_txn_io, sec_txn_mem;
   logic sec_txn_cfg, init_start_req, init_start_cfg, init_fwd_is_mwi, sec_claim_ff;
   logic pri_txn_io, pri_txn_mem, pri_txn_special, pri_txn_write, pri_claim_ff;
   logic addr_parity_err, data_parity_err, init_master_abort, init_target_abort;
   logic tgt_abort_sent, sys_error_req, pri_forward_palette_ff, init_start_ff;
   logic init_issue_mwi_ff, primary_parity_error_n_ff, primary_system_error_n_ff;
   logic primary_parity_error_in_n;
   logic [7:0]  cfg_addr;
   logic [3:0]  cfg_be, pk;
   logic [5:0]  ev;
   logic [31:0] cfg_wdata, pri_txn_addr, cfg_rdata_ff, rd;
   int          failures = 0;
   int          num_checks = 0;
   assign {pri_txn_mem, pri_txn_io, pri_txn_special, pri_txn_write} = pk;
   assign {addr_parity_err, data_parity_err, init_master_abort, init_target_abort,
           tgt_abort_sent, sys_error_req} = ev;
   always #2.5 clk = ~clk;
   pcs_host_model host (.clk, .report, .parity_error_n(primary_parity_error_in_n));
   pcs_regs uut (.clk, .sys_rst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
      .cfg_rdata_ff, .cfg_ack_ff, .pri_txn_valid, .pri_txn_io, .pri_txn_mem, .pri_txn_special,
      .pri_txn_write, .pri_txn_fast_b2b, .pri_txn_addr, .pri_in_io_window, .pri_in_mem_window,
      .pri_claim_ff, .pri_forward_palette_ff, .sec_txn_valid, .sec_txn_io, .sec_txn_mem,
      .sec_txn_cfg, .sec_claim_ff, .init_start_req, .init_start_cfg, .init_fwd_is_mwi,
      .init_start_ff, .init_issue_mwi_ff, .addr_parity_err, .data_parity_err, .init_active,
      .init_master_abort, .init_target_abort, .tgt_abort_sent, .sys_error_req,
      .primary_parity_error_in_n, .primary_parity_error_n_ff, .primary_system_error_n_ff);
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
      @(negedge clk);
      {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {wr, !wr, a, be, d};
      @(negedge clk);
      {cfg_wr, cfg_rd} = 2'h0;
      rd = cfg_rdata_ff;
      chk(cfg_ack_ff, 1'b1);
   endtask
   task automatic stat(input logic [31:0] exp);
      cfg(1'b0, 8'h04, 4'hf, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic pri(input logic [3:0] k, input logic [31:0] a, input logic [1:0] exp);
      @(negedge clk);
      {pri_txn_valid, pk, pri_txn_addr} = {1'b1, k, a};
      @(negedge clk);
      pri_txn_valid = 1'b0;
      chk({pri_claim_ff, pri_forward_palette_ff}, exp);
   endtask
   task automatic side(input logic [4:0] s, input logic [2:0] exp);
      @(negedge clk);
      {sec_txn_valid, sec_txn_io, sec_txn_cfg, sec_txn_mem, init_start_req, init_start_cfg,
       init_fwd_is_mwi} = {1'b1, s[4:2], 1'b1, s[1:0]};
      @(negedge clk);
      {sec_txn_valid, init_start_req} = 2'h0;
      chk({sec_claim_ff, init_start_ff, init_issue_mwi_ff}, exp);
   endtask
   task automatic pulse(input logic [5:0] e);
      @(negedge clk);
      ev = e;
      @(negedge clk);
      ev = 6'h00;
      repeat (3) @(negedge clk);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      stat(32'h02b0_0000);
      cfg(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
      stat(32'h02b0_0067);
      cfg(1'b0, 8'h04, 4'h3, 32'h0000_0000);
      chk(rd, 32'h0000_0067);
      cfg(1'b0, 8'h08, 4'hf, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("t_regs done");
   endtask
   task automatic t_claims;
      {pri_in_io_window, pri_in_mem_window, pri_txn_fast_b2b} = 3'h7;
      cfg(1'b1, 8'h04, 4'h1, 32'h0000_0000);
      pri(4'h9, 32'h0000_1000, 2'h0);
      pri(4'h5, 32'h0000_1000, 2'h0);
      side(5'h10, 3'h0);
      side(5'h0a, 3'h6);
      cfg(1'b1, 8'h04, 4'h1, 32'h0000_0007);
      pri(4'h9, 32'h0000_1000, 2'h2);
      pri(4'h4, 32'h0000_1000, 2'h2);
      pri(4'h2, 32'h0000_0000, 2'h0);
      side(5'h11, 3'h7);
      side(5'h07, 3'h6);
      pri_in_mem_window = 1'b0;
      pri(4'h8, 32'h0000_1000, 2'h0);
      $display("t_claims done");
   endtask
   task automatic t_palette;
      {pri_in_io_window, pri_txn_fast_b2b} = 2'h0;
      pri(4'h5, 32'h0000_03c8, 2'h0);
      cfg(1'b1, 8'h04, 4'h1, 32'h0000_0027);
      pri(4'h5, 32'h0000_03c8, 2'h3);
      pri(4'h5, 32'h0000_03c6, 2'h3);
      pri(4'h5, 32'h0000_ffc9, 2'h3);
      pri(4'h5, 32'h0001_03c9, 2'h0);
      pri(4'h5, 32'h0000_03c7, 2'h0);
      pri(4'h4, 32'h0000_03c8, 2'h0);
      $display("t_palette done");
   endtask
   task automatic t_flags;
      cfg(1'b1, 8'h04, 4'h1, 32'h0000_0067);
      init_active = 1'b1;
      for (int i = 0; i < 6; i++) pulse(6'h20 >> i);
      stat(32'hfbb0_0067);
      cfg(1'b1, 8'h04, 4'h8, 32'h0800_0000);
      stat(32'hf3b0_0067);
      cfg(1'b1, 8'h04, 4'h4, 32'hffff_0000);
      stat(32'hf3b0_0067);
      cfg(1'b1, 8'h04, 4'h8, 32'hff00_0000);
      stat(32'h02b0_0067);
      @(negedge clk);
      report = 1'b1;
      @(negedge clk);
      report = 1'b0;
      repeat (6) @(negedge clk);
      stat(32'h03b0_0067);
      cfg(1'b1, 8'h04, 4'h9, 32'hff00_0007);
      pulse(6'h10);
      init_active = 1'b0;
      pulse(6'h0c);
      stat(32'h82b0_0007);
      @(negedge clk);
      sys_rst = 1'b1;
      @(negedge clk);
      sys_rst = 1'b0;
      stat(32'h02b0_0000);
      $display("t_flags done");
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {cfg_rd, cfg_wr, pri_txn_valid, pri_txn_fast_b2b, report, init_active} = 6'h00;
      {pri_in_io_window, pri_in_mem_window, sec_txn_valid, sec_txn_io, sec_txn_mem} = 5'h00;
      {sec_txn_cfg, init_start_req, init_start_cfg, init_fwd_is_mwi} = 4'h0;
      {cfg_addr, cfg_be, pk, ev, cfg_wdata, pri_txn_addr} = '0;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      t_regs();
      t_claims();
      t_palette();
      t_flags();
      summarize();
   end
   initial begin
      #20000;
      failures++;
      summarize();
   end
endmodule // pcs_regs_bench
bind pcs_regs pcs_regs_checker chk_i (.*);
`default_nettype wire
